// [rtl/prs_defs.svh]
// register map, field positions and reset values for the ratio and pin select block
// Summary of operation
// [R01] synthesiser powered only while enable bit set
// [R02] software computes fraction from desired ratio
// [R03] software keeps integer ratio between 5, 13
// [R04] prescale bit halves reference into synthesiser
// [R05] three registers form one 24-bit fraction
// [R06] fixed divide-by-4 then optional divide-by-2
// [R07] pin a driven per function code, invertible
// [R08] pin b same encoding, input means jack
// [R09] pin clock divided by 1 to 4
// [R10] both pins inputs after reset
// [R11] 3-wire mode forces pin a chip select
// [R12] pin a input: chip select or jack
// [R13] pin b input serves jack detection
// [R14] line input pin offers jack detection
// [R15] software aims near 90MHz, integer eight
// [R16] core clock source bit selects reference/synth
// [R17] core clock scaler code divides selected clock
// [R18] system straps interface-select pin low/high
// [R19] lock held inactive while synthesiser disabled
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH
// ----------------------------------------
// register offsets (7-bit control word address)
// ----------------------------------------
`define PRS_OFS_POWER_MGMT_ONE 7'h01
`define PRS_OFS_CLOCK_GEN 7'h06
`define PRS_OFS_PIN_A_CTRL 7'h08
`define PRS_OFS_PIN_B_CTRL 7'h09
`define PRS_OFS_SYNTH_INT 7'h24
`define PRS_OFS_FRAC_HIGH 7'h25
`define PRS_OFS_FRAC_MID 7'h26
`define PRS_OFS_FRAC_LOW 7'h27
// ----------------------------------------
// field positions
// ----------------------------------------
`define PRS_BIT_SYNTH_ENABLE 5
`define PRS_BIT_REF_HALVE 4
`define PRS_BIT_CORE_SRC 8
`define PRS_BIT_POST_HALVE 0
`define PRS_BIT_INVERT 3
// ----------------------------------------
// reset values
// ----------------------------------------
`define PRS_RST_POWER_MGMT_ONE 9'h000
`define PRS_RST_CLOCK_GEN 9'h140
`define PRS_RST_PIN_CTRL 9'h000
`define PRS_RST_SYNTH_INT 9'h008
`define PRS_RST_FRAC_HIGH 9'h00c
`define PRS_RST_FRAC_MID 9'h093
`define PRS_RST_FRAC_LOW 9'h0e9
// ----------------------------------------
// divider figures
// ----------------------------------------
`define PRS_FIXED_DIV 4
`endif

// [rtl/prs_pkg.sv]
// types shared by the ratio and pin select block
package prs_pkg;
  typedef enum logic [2:0] {
    PRS_FN_INPUT = 3'h0,
    PRS_FN_RESERVED = 3'h1,
    PRS_FN_TEMP_OK = 3'h2,
    PRS_FN_AUTO_MUTE = 3'h3,
    PRS_FN_SYNTH_CLK = 3'h4,
    PRS_FN_LOCK = 3'h5,
    PRS_FN_ONE = 3'h6,
    PRS_FN_ZERO = 3'h7
  } prs_pin_fn_e;
  typedef logic [8:0] prs_reg_t;
endpackage

// [rtl/prs_ratio_pin_select.sv]
// synthesiser ratio registers, core clock selection and multipurpose pin functions
`timescale 1ns/1ps
`include "prs_defs.svh"
module prs_ratio_pin_select (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] ctrlWord,
  input wire logic ctrlWordValid,
  input wire logic [6:0] readAddr,
  output logic [8:0] readData,
  input wire logic synthClockRaw,
  input wire logic synthLockRaw,
  input wire logic tempOk,
  input wire logic autoMuteActive,
  input wire logic interfaceSelect,
  input wire logic lineInDetectPin,
  input wire logic pinAIn,
  output logic pinAOut,
  output logic pinAOe,
  input wire logic pinBIn,
  output logic pinBOut,
  output logic pinBOe,
  output logic chipSelectIn,
  output logic jackSenseA,
  output logic jackSenseB,
  output logic jackSenseLine,
  output logic synthPowerOn,
  output logic synthRefHalve,
  output logic [3:0] synthInteger,
  output logic [23:0] synthFraction,
  output logic synthLock,
  output logic coreClockSource,
  output logic [2:0] coreClockScaler
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rstMeta;
  logic rstSync;
  // assert at once, release two edges later so no flop leaves reset mid-cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ----------------------------------------
  // pin input synchronisers
  // ----------------------------------------
  logic [5:0] asyncIn;
  logic [5:0] syncMeta;
  logic [5:0] syncIn;
  assign asyncIn = {synthClockRaw, synthLockRaw, interfaceSelect, lineInDetectPin, pinAIn, pinBIn};
  // two stages each; only the second stage is read anywhere
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      syncMeta <= 6'h00;
      syncIn <= 6'h00;
    end else begin
      syncMeta <= asyncIn;
      syncIn <= syncMeta;
    end
  end
  logic synthClkS, lockS, threeWire, lineInS, pinAS, pinBS;
  assign {synthClkS, lockS, threeWire, lineInS, pinAS, pinBS} = syncIn;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  prs_pkg::prs_reg_t powerMgmtOne, clockGen, pinACtrl, pinBCtrl;
  prs_pkg::prs_reg_t synthIntReg, fracHigh, fracMid, fracLow;
  logic [6:0] wrAddr;
  logic [8:0] wrData;
  assign wrAddr = ctrlWord[15:9];
  assign wrData = ctrlWord[8:0];
  // one 16-bit word per strobe: 7 address bits then 9 data bits
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      powerMgmtOne <= `PRS_RST_POWER_MGMT_ONE; // [R01]
      clockGen <= `PRS_RST_CLOCK_GEN; // [R16] [R17]
      pinACtrl <= `PRS_RST_PIN_CTRL; // [R10]
      pinBCtrl <= `PRS_RST_PIN_CTRL; // [R08] [R10]
      synthIntReg <= `PRS_RST_SYNTH_INT; // [R03] [R04]
      fracHigh <= `PRS_RST_FRAC_HIGH; // [R05]
      fracMid <= `PRS_RST_FRAC_MID;
      fracLow <= `PRS_RST_FRAC_LOW;
    end else if (ctrlWordValid) begin
      unique case (wrAddr)
        `PRS_OFS_POWER_MGMT_ONE: powerMgmtOne <= wrData;
        `PRS_OFS_CLOCK_GEN: clockGen <= wrData;
        `PRS_OFS_PIN_A_CTRL: pinACtrl <= {3'h0, wrData[5:0]};
        `PRS_OFS_PIN_B_CTRL: pinBCtrl <= wrData;
        `PRS_OFS_SYNTH_INT: synthIntReg <= {4'h0, wrData[4:0]};
        `PRS_OFS_FRAC_HIGH: fracHigh <= {3'h0, wrData[5:0]};
        `PRS_OFS_FRAC_MID: fracMid <= wrData;
        `PRS_OFS_FRAC_LOW: fracLow <= wrData;
        default: ; // other addresses belong to other blocks
      endcase
    end
  end

  // read-back of the stored values, unmapped addresses read zero
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      readData <= 9'h000;
    end else begin
      unique case (readAddr)
        `PRS_OFS_POWER_MGMT_ONE: readData <= powerMgmtOne;
        `PRS_OFS_CLOCK_GEN: readData <= clockGen;
        `PRS_OFS_PIN_A_CTRL: readData <= pinACtrl;
        `PRS_OFS_PIN_B_CTRL: readData <= pinBCtrl;
        `PRS_OFS_SYNTH_INT: readData <= synthIntReg;
        `PRS_OFS_FRAC_HIGH: readData <= fracHigh;
        `PRS_OFS_FRAC_MID: readData <= fracMid;
        `PRS_OFS_FRAC_LOW: readData <= fracLow;
        default: readData <= 9'h000;
      endcase
    end
  end

  // ----------------------------------------
  // synthesiser controls
  // ----------------------------------------
  // integer range is software's duty; stored as written, no clamping
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      synthPowerOn <= 1'b0;
      synthRefHalve <= 1'b0;
      synthInteger <= 4'h8;
      synthFraction <= 24'h00_0000;
      coreClockSource <= 1'b1;
      coreClockScaler <= 3'h2;
      synthLock <= 1'b0;
    end else begin
      synthPowerOn <= powerMgmtOne[`PRS_BIT_SYNTH_ENABLE]; // [R01]
      synthRefHalve <= synthIntReg[`PRS_BIT_REF_HALVE]; // [R04]
      synthInteger <= synthIntReg[3:0]; // [R03]
      synthFraction <= {fracHigh[5:0], fracMid, fracLow}; // [R05] [R02]
      coreClockSource <= clockGen[`PRS_BIT_CORE_SRC]; // [R16]
      coreClockScaler <= clockGen[7:5]; // [R17]
      synthLock <= powerMgmtOne[`PRS_BIT_SYNTH_ENABLE] & lockS; // [R19]
    end
  end

  // ----------------------------------------
  // pin clock divider
  // ----------------------------------------
  // total ratio = 4 x (1 or 2) x (1..4); always even, so a clean 50% duty
  logic synthClkPrev;
  logic [4:0] divCount;
  logic [5:0] divTotal;
  logic [4:0] next_divCount;
  logic pinClock;
  // six bits: the largest ratio, 32, would wrap to zero in the counter's width
  assign divTotal = 6'(`PRS_FIXED_DIV * (clockGen[`PRS_BIT_POST_HALVE] ? 2 : 1)
                       * ({1'b0, pinACtrl[5:4]} + 3'd1)); // [R06] [R09]
  assign next_divCount = ({1'b0, divCount} >= divTotal - 6'd1) ? 5'd0 : divCount + 5'd1;
  // counts synth edges seen on the system clock; synth must run below half clk
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      synthClkPrev <= 1'b0;
      divCount <= 5'd0;
      pinClock <= 1'b0;
    end else begin
      synthClkPrev <= synthClkS;
      if (!powerMgmtOne[`PRS_BIT_SYNTH_ENABLE]) begin
        divCount <= 5'd0; // [R01]
        pinClock <= 1'b0;
      end else if (synthClkS && !synthClkPrev) begin
        divCount <= next_divCount;
        pinClock <= {1'b0, next_divCount} < (divTotal >> 1);
      end
    end
  end

  // ----------------------------------------
  // multipurpose pins
  // ----------------------------------------
  function automatic logic pin_level(input logic [2:0] fn, input logic inv,
                                     input logic tOk, input logic aMute,
                                     input logic sClk, input logic lk);
    logic v;
    v = 1'b0;
    unique case (prs_pkg::prs_pin_fn_e'(fn))
      prs_pkg::PRS_FN_TEMP_OK: v = tOk;
      prs_pkg::PRS_FN_AUTO_MUTE: v = aMute;
      prs_pkg::PRS_FN_SYNTH_CLK: v = sClk;
      prs_pkg::PRS_FN_LOCK: v = lk;
      prs_pkg::PRS_FN_ONE: v = 1'b1;
      prs_pkg::PRS_FN_ZERO: v = 1'b0;
      prs_pkg::PRS_FN_INPUT, prs_pkg::PRS_FN_RESERVED: v = 1'b0;
    endcase
    pin_level = v ^ inv;
  endfunction

  logic lockNow;
  assign lockNow = powerMgmtOne[`PRS_BIT_SYNTH_ENABLE] & lockS; // [R19]
  // reserved code is treated like input so it never drives the pin
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pinAOut <= 1'b0;
      pinAOe <= 1'b0; // [R10]
      pinBOut <= 1'b0;
      pinBOe <= 1'b0; // [R10]
    end else begin
      pinAOut <= pin_level(pinACtrl[2:0], pinACtrl[`PRS_BIT_INVERT], tempOk,
                           autoMuteActive, pinClock, lockNow); // [R07]
      pinAOe <= !threeWire && pinACtrl[2:1] != 2'b00; // [R11] [R07]
      pinBOut <= pin_level(pinBCtrl[2:0], pinBCtrl[`PRS_BIT_INVERT], tempOk,
                           autoMuteActive, pinClock, lockNow); // [R08]
      pinBOe <= pinBCtrl[2:1] != 2'b00; // [R08]
    end
  end

  // input roles; polarity invert does not apply to sensed levels
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      chipSelectIn <= 1'b1;
      jackSenseA <= 1'b0;
      jackSenseB <= 1'b0;
      jackSenseLine <= 1'b0;
    end else begin
      chipSelectIn <= threeWire ? pinAS : 1'b1; // [R11] [R12] [R18]
      jackSenseA <= !threeWire && pinACtrl[2:0] == 3'h0 && pinAS; // [R12]
      jackSenseB <= pinBCtrl[2:0] == 3'h0 && pinBS; // [R13]
      jackSenseLine <= lineInS; // [R14]
    end
  end
endmodule

// [tb/prs_checker_properties.sv]
// port assertions for the ratio and pin select block
`timescale 1ns/1ps
module prs_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] ctrlWord,
  input wire logic ctrlWordValid,
  input wire logic [6:0] readAddr,
  input wire logic [8:0] readData,
  input wire logic interfaceSelect,
  input wire logic pinAIn,
  input wire logic pinAOe,
  input wire logic pinBOe,
  input wire logic chipSelectIn,
  input wire logic synthPowerOn,
  input wire logic synthRefHalve,
  input wire logic [3:0] synthInteger,
  input wire logic [23:0] synthFraction,
  input wire logic synthLock,
  input wire logic coreClockSource,
  input wire logic [2:0] coreClockScaler
);
  // ----------------------------------------
  // register writes reach outputs two edges on
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_power_bit_follows: assert property (ctrlWordValid && ctrlWord[15:9] == 7'h01
    |-> ##2 synthPowerOn == $past(ctrlWord[5], 2)) else $error("power bit wrong");
  a_ratio_int_follows: assert property (ctrlWordValid && ctrlWord[15:9] == 7'h24
    |-> ##2 {synthRefHalve, synthInteger} == $past(ctrlWord[4:0], 2)) else $error("integer ratio wrong");
  a_frac_low_follows: assert property (ctrlWordValid && ctrlWord[15:9] == 7'h27
    |-> ##2 synthFraction[8:0] == $past(ctrlWord[8:0], 2)) else $error("fraction low wrong");
  a_core_clock_follows: assert property (ctrlWordValid && ctrlWord[15:9] == 7'h06
    |-> ##2 {coreClockSource, coreClockScaler} == $past(ctrlWord[8:5], 2)) else $error("core clock wrong");
  a_read_mid_frac: assert property (readAddr == 7'h26 |=> readData == synthFraction[17:9])
    else $error("read back wrong");
  a_pins_idle_reset: assert property ($rose(reset_n) |-> !pinAOe && !pinBOe) else $error("pin driven");
  a_lock_needs_power: assert property (!synthPowerOn [*2] |-> !synthLock) else $error("lock while off");
  a_cs_three_wire: assert property (interfaceSelect [*5] |-> !pinAOe && chipSelectIn == $past(pinAIn, 3))
    else $error("chip select wrong");
  a_cs_two_wire: assert property (!interfaceSelect [*5] |-> chipSelectIn) else $error("select active");
endmodule
bind prs_ratio_pin_select prs_checker chk_i (.clk, .reset_n, .ctrlWord, .ctrlWordValid, .readAddr, .readData,
  .interfaceSelect, .pinAIn, .pinAOe, .pinBOe, .chipSelectIn, .synthPowerOn, .synthRefHalve, .synthInteger,
  .synthFraction, .synthLock, .coreClockSource, .coreClockScaler);

// [tb/prs_far_side.sv]
// model of the synthesiser loop feeding the block
`timescale 1ns/1ps
module prs_far_side (
  input wire logic powerOn,
  output logic synthClockRaw,
  output logic synthLockRaw
);
  int edges;
  // clock stands low and lock drops while unpowered; settles after 20 edges
  initial begin
    synthClockRaw = 1'b0;
    synthLockRaw = 1'b0;
    edges = 0;
    forever begin
      #40;
      if (powerOn) begin
        synthClockRaw = ~synthClockRaw;
        edges++;
        synthLockRaw = edges > 20;
      end else begin
        synthClockRaw = 1'b0;
        synthLockRaw = 1'b0;
        edges = 0;
      end
    end
  end
endmodule

// [tb/testbench.sv]
// self-checking bench for the ratio and pin select block
`timescale 1ns/1ps
module testbench;
  logic clk, reset_n, ctrlWordValid, tempOk, autoMuteActive, interfaceSelect, lineInDetectPin, pinAIn, pinBIn;
  logic synthClockRaw, synthLockRaw, pinAOut, pinAOe, pinBOut, pinBOe, chipSelectIn, jackSenseA, jackSenseB;
  logic jackSenseLine, synthPowerOn, synthRefHalve, synthLock, coreClockSource;
  logic [15:0] ctrlWord;
  logic [6:0] readAddr;
  logic [8:0] readData, rv;
  logic [3:0] synthInteger;
  logic [23:0] synthFraction;
  logic [2:0] coreClockScaler;
  int err_count, n_checks, n;
  prs_ratio_pin_select uut (.clk, .reset_n, .ctrlWord, .ctrlWordValid, .readAddr, .readData, .synthClockRaw,
    .synthLockRaw, .tempOk, .autoMuteActive, .interfaceSelect, .lineInDetectPin, .pinAIn, .pinAOut, .pinAOe, .pinBIn,
    .pinBOut, .pinBOe, .chipSelectIn, .jackSenseA, .jackSenseB, .jackSenseLine, .synthPowerOn, .synthRefHalve,
    .synthInteger, .synthFraction, .synthLock, .coreClockSource, .coreClockScaler);
  prs_far_side far (.powerOn(synthPowerOn), .synthClockRaw, .synthLockRaw);
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // write then let the derived outputs settle
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk) #1;
    ctrlWord = {a, d};
    ctrlWordValid = 1'b1;
    @(posedge clk) #1;
    ctrlWordValid = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [6:0] a);
    readAddr = a;
    @(posedge clk) #1;
    rv = readData;
  endtask
  // wait for a level on pin a output; bounded so a dead divider cannot hang
  task automatic until_a(input logic v);
    while (pinAOut !== v && n < 600) begin
      @(posedge clk) #1;
      n++;
    end
    if (n >= 600) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic pin_case(input bit b, input logic [2:0] c, input logic inv);
    logic e;
    wr(b ? 7'h09 : 7'h08, {5'h00, inv, c});
    e = (c == 3'h2) ? tempOk : (c == 3'h3) ? autoMuteActive : (c == 3'h5 || c == 3'h6);
    chk(b ? pinBOe : pinAOe, c > 3'h1);
    if (c > 3'h1 && c != 3'h4) chk(b ? pinBOut : pinAOut, e ^ inv);
    if (c == 3'h0) chk(b ? jackSenseB : jackSenseA, inv);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_n, ctrlWord, ctrlWordValid, readAddr, autoMuteActive, interfaceSelect, pinAIn, pinBIn} = '0;
    tempOk = 1'b1;
    lineInDetectPin = 1'b1;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({synthPowerOn, synthRefHalve, synthInteger}, 6'h08);
    chk(synthFraction, 24'h31_26e9);
    chk({coreClockSource, coreClockScaler, pinAOe, pinBOe, chipSelectIn, jackSenseLine}, 8'ha3);
    wr(7'h24, 9'h017);
    chk({synthRefHalve, synthInteger}, 5'h17);
    wr(7'h25, 9'h1e1);
    wr(7'h26, 9'h161);
    wr(7'h27, 9'h027);
    chk(synthFraction, 24'h86_c227);
    rd(7'h25);
    chk(rv, 9'h021);
    rd(7'h26);
    chk(rv, 9'h161);
    rd(7'h7f);
    chk(rv, 9'h000);
    wr(7'h01, 9'h020);
    n = 0;
    while (synthLock !== 1'b1 && n < 400) begin
      @(posedge clk) #1;
      n++;
    end
    chk({synthPowerOn, synthLock}, 2'h3);
    if (n >= 400) stop_test();
    for (int k = 0; k < 16; k++) begin
      {pinAIn, pinBIn, tempOk} = {3{k[3]}};
      pin_case(0, k[2:0], k[3]);
      pin_case(1, k[2:0], k[3]);
    end
    for (int d = 0; d < 4; d++) begin
      wr(7'h06, {8'h50, d == 3});
      chk({coreClockSource, coreClockScaler}, 4'h5);
      wr(7'h08, {3'h0, 2'(d), 4'h4});
      n = 0;
      until_a(1'b0);
      until_a(1'b1);
      n = 0;
      until_a(1'b0);
      until_a(1'b1);
      chk(n, 32 * (d + 1) * (d == 3 ? 2 : 1));
    end
    {interfaceSelect, lineInDetectPin, pinAIn} = 3'h4;
    wr(7'h08, 9'h006);
    chk({pinAOe, chipSelectIn, jackSenseLine}, 3'h0);
    interfaceSelect = 1'b0;
    wr(7'h01, 9'h000);
    chk({synthPowerOn, synthLock, chipSelectIn}, 3'h1);
    stop_test();
  end
endmodule
